// File: bench/link_master.sv
`timescale 1ns/1ps
module link_master (
  // read side
  input  wire logic       LINK_CLK,
  input  wire logic [7:0] LINK_RD_BYTE,
  input  wire logic       LINK_RD_READY,
  // requests
  output logic            LINK_START,
  output logic            LINK_READ,
  output logic            LINK_GCALL,
  output logic            LINK_WR_VALID,
  output logic [7:0]      LINK_WR_BYTE,
  output logic            LINK_RD_TAKE
);
  initial {LINK_START, LINK_READ, LINK_GCALL, LINK_WR_VALID, LINK_RD_TAKE,
           LINK_WR_BYTE} = 13'h0000;
  // byte lines scrambled when not valid, never left stale
  task automatic sig(input logic [4:0] c, input logic [7:0] b);
    @(negedge LINK_CLK);
    {LINK_START, LINK_READ, LINK_GCALL, LINK_WR_VALID, LINK_RD_TAKE} = c;
    LINK_WR_BYTE = c[1] ? b : ~LINK_WR_BYTE;
  endtask
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    sig(5'h10, 8'h00);
    sig(5'h02, p);
    sig(5'h02, d[15:8]);
    sig(5'h02, d[7:0]);
    sig(5'h00, 8'h00);
    repeat (8) @(negedge LINK_CLK);
  endtask
  task automatic rd(input logic [7:0] p, output logic [15:0] d);
    int n;
    sig(5'h10, 8'h00);
    sig(5'h02, p);
    sig(5'h00, 8'h00);
    repeat (4) @(negedge LINK_CLK);
    sig(5'h18, 8'h00);
    sig(5'h00, 8'h00);
    repeat (2) @(negedge LINK_CLK);
    n = 0;
    while (LINK_RD_READY !== 1'b1 && n < 60) begin
      @(negedge LINK_CLK);
      n++;
    end
    d[15:8] = LINK_RD_BYTE;
    sig(5'h01, 8'h00);
    sig(5'h00, 8'h00);
    d[7:0] = LINK_RD_BYTE;
    repeat (2) @(negedge LINK_CLK);
  endtask
  task automatic gcall;
    sig(5'h14, 8'h00);
    sig(5'h02, 8'h06);
    sig(5'h00, 8'h00);
    repeat (8) @(negedge LINK_CLK);
  endtask
endmodule

// File: bench/temp_sensor_register_bank_test.sv
`timescale 1ns/1ps
`include "temp_sensor_consts.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin errors++; \
  $display("unexpected %0t %h %h", $time, a, e); end end
module temp_sensor_register_bank_test;
  import temp_sensor_pkg::*;
  // arbitrary identifier value
  localparam logic [15:0] PID = 16'h5A3C;
  localparam logic [15:0] CW [5] = '{16'h0C00, 16'h0C00, 16'h0C10,
                                     16'h0C10, 16'h0C0C};
  localparam logic [15:0] AD [5] = '{16'h0200, 16'h0050, 16'h0200,
                                     16'h0050, 16'h0090};
  localparam logic [15:0] E1 [5] = '{16'hA400, 16'h6400, 16'hA410,
                                     16'h2410, 16'h240C};
  localparam logic [15:0] E2 [5] = '{16'h0400, 16'h0400, 16'h8410,
                                     16'h0410, 16'h040C};
  localparam logic [4:0]  PN     = 5'b11000;
  logic        clk = 0, lclk = 0, reset_n = 0, adc_v = 0, busy = 0;
  logic [2:0]  ac = 3'h0, ri, wi;
  logic [15:0] adc = 16'h0000, nq = 16'h0000, d, wd;
  logic [15:0] nvm [0:7];
  logic        st, rm, gc, wv, tk, rdy, act, nw, pin;
  logic [7:0]  wb, rb;
  int          errors = 0, n_compared = 0;
  always #20 clk = ~clk;
  initial begin
    #7;
    forever #32 lclk = ~lclk;
  end
  temp_sensor_register_bank #(.TICK_CYC(4), .PART_ID(PID)) DUT (
    .CLK(clk), .RESET_N(reset_n), .LINK_CLK(lclk), .LINK_START(st),
    .LINK_READ(rm), .LINK_GCALL(gc), .LINK_WR_VALID(wv),
    .LINK_WR_BYTE(wb), .LINK_RD_TAKE(tk), .LINK_RD_BYTE(rb),
    .LINK_RD_READY(rdy), .ADC_VALID(adc_v), .ADC_SAMPLE(adc),
    .CONV_ACTIVE(act), .NVM_RD_INDEX(ri), .NVM_RD_DATA(nq), .NVM_WR(nw),
    .NVM_WR_INDEX(wi), .NVM_WR_DATA(wd), .NVM_BUSY(busy), .EVENT_PIN(pin));
  link_master LM (
    .LINK_CLK(lclk), .LINK_RD_BYTE(rb), .LINK_RD_READY(rdy),
    .LINK_START(st), .LINK_READ(rm), .LINK_GCALL(gc),
    .LINK_WR_VALID(wv), .LINK_WR_BYTE(wb), .LINK_RD_TAKE(tk));
  // stored memory, one cycle read latency
  always @(posedge clk) begin
    nq <= nvm[ri];
    if (nw === 1'b1) nvm[wi] <= wd;
  end
  always @(negedge clk) begin
    ac <= ac + 3'h1;
    adc_v <= (ac == 3'h0);
  end
  task t_reset;
    LM.rd(`ADDR_RESULT, d);
    `CHK(d, `RESULT_RST)
    LM.rd(`ADDR_CTRL, d);
    `CHK(d, `CTRL_FACT)
    LM.rd(`ADDR_UPPER, d);
    `CHK(d, 16'h0C80)
    LM.wr(`ADDR_RESULT, 16'h1234);
    LM.rd(`ADDR_RESULT, d);
    `CHK(d, `RESULT_RST)
    LM.wr(`ADDR_CTRL, 16'h0403);
    // running conversion finishes before power-down, done flag set
    repeat (150) @(negedge clk);
    LM.rd(`ADDR_CTRL, d);
    `CHK(d, 16'h2400)
  endtask
  task t_shot;
    LM.wr(`ADDR_UPPER, 16'h0100);
    LM.wr(`ADDR_LOWER, 16'h0080);
    repeat (1100) @(negedge clk);
    LM.rd(`ADDR_CTRL, d);
    for (int i = 0; i < 5; i++) begin
      adc = AD[i];
      LM.wr(`ADDR_CTRL, CW[i]);
      repeat (200) @(negedge clk);
      `CHK(pin, PN[i])
      LM.rd(`ADDR_CTRL, d);
      `CHK(d, E1[i])
      LM.rd(`ADDR_CTRL, d);
      `CHK(d, E2[i])
    end
    LM.rd(`ADDR_RESULT, d);
    `CHK(d, 16'h0090)
    LM.wr(`ADDR_CTRL, 16'h0800);
    LM.rd(`ADDR_CTRL, d);
    `CHK(d & 16'h0FFF, 16'h0000)
  endtask
  task t_period;
    int n;
    LM.wr(`ADDR_CTRL, 16'h0080);
    // skip whatever cycle was running when the write landed
    repeat (2) begin
      while (act !== 1'b0) @(negedge clk);
      while (act !== 1'b1) @(negedge clk);
    end
    n = 0;
    while (act === 1'b1) begin
      n++;
      @(negedge clk);
    end
    `CHK(n, `ACT0_US / `TICK_US * 4)
    n = 0;
    while (act === 1'b0) begin
      n++;
      @(negedge clk);
    end
    `CHK(n, (`PER1_US - `ACT0_US) / `TICK_US * 4)
  endtask
  task t_nvm;
    LM.wr(`ADDR_GATE, 16'h8000);
    @(negedge clk);
    busy = 1'b1;
    LM.rd(`ADDR_GATE, d);
    `CHK(d, 16'hC000)
    @(negedge clk);
    busy = 1'b0;
    LM.wr(8'h06, 16'hBEEF);
    repeat (10) @(negedge clk);
    `CHK(nvm[4], 16'hBEEF)
    LM.rd(8'h06, d);
    `CHK(d, 16'hBEEF)
    LM.gcall;
    repeat (20) @(negedge clk);
    LM.rd(`ADDR_RESULT, d);
    `CHK(d, `RESULT_RST)
    LM.rd(`ADDR_GATE, d);
    `CHK(d, 16'h0000)
    LM.rd(`ADDR_UPPER, d);
    `CHK(d, 16'h0C80)
    LM.rd(`ADDR_PART, d);
    `CHK(d, PID)
  endtask
  task results;
    if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 8; i++) nvm[i] = 16'h0000;
    nvm[0] = `CTRL_FACT;
    nvm[1] = 16'h0C80;
    nvm[2] = `LOWER_FACT;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (12) @(negedge clk);
    t_reset;
    t_shot;
    t_nvm;
    t_period;
    results;
  end
  // run needs about 6000 cycles; allow far more
  initial begin
    #1000000;
    errors++;
    results;
  end
endmodule

// File: rtl/temp_sensor_consts.svh
`ifndef TEMP_SENSOR_CONSTS_SVH
`define TEMP_SENSOR_CONSTS_SVH
// register pointers
`define ADDR_RESULT   8'h00
`define ADDR_CTRL     8'h01
`define ADDR_UPPER    8'h02
`define ADDR_LOWER    8'h03
`define ADDR_GATE     8'h04
`define ADDR_SCR1     8'h05
`define ADDR_SCR4     8'h08
`define ADDR_PART     8'h0F
// control word fields
`define CW_HI         15
`define CW_LO         14
`define CW_DR         13
`define CW_BUSY       12
`define CW_MODE_HI    11
`define CW_MODE_LO    10
`define CW_CONV_HI    9
`define CW_CONV_LO    7
`define CW_AVG_HI     6
`define CW_AVG_LO     5
`define CW_TN         4
`define CW_POL        3
`define CW_SRC        2
`define GATE_OPEN     15
`define GATE_BUSY     14
// run schemes
`define MODE_FREE     2'b00
`define MODE_DOWN     2'b01
`define MODE_ALT      2'b10
`define MODE_SHOT     2'b11
// reset values
`define RESULT_RST    16'h8000
`define CTRL_FACT     16'h0220
`define UPPER_FACT    16'h6000
`define LOWER_FACT    16'h8000
`define SCR_RST       16'h0000
`define GC_RESET_CMD  8'h06
`define NVM_WORDS     3'h7
// result lsb in millidegrees C
`define RESULT_LSB_MC 7.8125
// samples per average
`define AVG_N0        7'h01
`define AVG_N1        7'h08
`define AVG_N2        7'h20
`define AVG_N3        7'h40
// timing
`define CLK_MHZ       25
`define TICK_US       500
`define ACT0_US       15500
`define ACT1_US       125000
`define ACT2_US       500000
`define ACT3_US       1000000
`define PER1_US       125000
`define PER2_US       250000
`define PER3_US       500000
`define PER4_US       1000000
`define PER5_US       4000000
`define PER6_US       8000000
`define PER7_US       16000000
`endif

// File: rtl/temp_sensor_pkg.sv
package temp_sensor_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_ACTIVE, ST_STANDBY}
    conv_state_e;
  typedef enum logic [2:0] {L_IDLE, L_PTR, L_WHI, L_WLO, L_GC, L_RD}
    link_phase_e;
endpackage

// File: rtl/temp_sensor_register_bank.sv
`timescale 1ns/1ps
`include "temp_sensor_consts.svh"
module temp_sensor_register_bank
  import temp_sensor_pkg::*;
#(
  parameter int unsigned TICK_CYC = `TICK_US * `CLK_MHZ,
  // arbitrary identifier value
  parameter logic [15:0] PART_ID  = 16'hA5C3
) (
  // system
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // byte link, on LINK_CLK
  input  wire logic        LINK_CLK,
  input  wire logic        LINK_START,
  input  wire logic        LINK_READ,
  input  wire logic        LINK_GCALL,
  input  wire logic        LINK_WR_VALID,
  input  wire logic [7:0]  LINK_WR_BYTE,
  input  wire logic        LINK_RD_TAKE,
  output logic      [7:0]  LINK_RD_BYTE,
  output logic             LINK_RD_READY,
  // measurement
  input  wire logic        ADC_VALID,
  input  wire logic [15:0] ADC_SAMPLE,
  output logic             CONV_ACTIVE,
  // stored codes
  output logic      [2:0]  NVM_RD_INDEX,
  input  wire logic [15:0] NVM_RD_DATA,
  output logic             NVM_WR,
  output logic      [2:0]  NVM_WR_INDEX,
  output logic      [15:0] NVM_WR_DATA,
  input  wire logic        NVM_BUSY,
  // event pin
  output logic             EVENT_PIN
);

  // link domain
  link_phase_e ph_q;
  logic [7:0]  ptr_q;
  logic [7:0]  rd_ptr_q;
  logic [7:0]  wr_ptr_q;
  logic [7:0]  whi_q;
  logic [15:0] wr_word_q;
  logic        wr_tog_q;
  logic        rd_tog_q;
  logic        gc_tog_q;
  logic        rd_lo_q;
  logic [1:0]  ack_sync_q;
  logic        rdy_q;
  logic [7:0]  rd_byte_q;
  logic        take_ok;
  word_t       snap_q;
  logic        rd_ack_q;

  assign take_ok = LINK_RD_TAKE && (ph_q == L_RD) && rdy_q;

  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ph_q      <= L_IDLE;
      ptr_q     <= 8'h00;
      rd_ptr_q  <= 8'h00;
      wr_ptr_q  <= 8'h00;
      whi_q     <= 8'h00;
      wr_word_q <= 16'h0000;
      wr_tog_q  <= 1'b0;
      rd_tog_q  <= 1'b0;
      gc_tog_q  <= 1'b0;
    end else if (LINK_START) begin
      if (LINK_GCALL) begin
        ph_q <= L_GC;
      end else if (LINK_READ) begin
        ph_q     <= L_RD;
        rd_ptr_q <= ptr_q;
        rd_tog_q <= ~rd_tog_q;
      end else begin
        ph_q <= L_PTR;
      end
    end else if (LINK_WR_VALID) begin
      case (ph_q)
        L_PTR: begin
          ptr_q <= LINK_WR_BYTE;
          ph_q  <= L_WHI;
        end
        L_WHI: begin
          whi_q <= LINK_WR_BYTE;
          ph_q  <= L_WLO;
        end
        L_WLO: begin
          wr_word_q <= {whi_q, LINK_WR_BYTE};
          wr_ptr_q  <= ptr_q;
          wr_tog_q  <= ~wr_tog_q;
          ph_q      <= L_WHI;
        end
        L_GC: begin
          if (LINK_WR_BYTE == `GC_RESET_CMD) begin
            gc_tog_q <= ~gc_tog_q;
          end
          ph_q <= L_IDLE;
        end
        default: begin
        end
      endcase
    end
  end

  // snapshot is stable once the ack toggle has been seen here
  always_ff @(posedge LINK_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ack_sync_q <= 2'b00;
      rdy_q      <= 1'b0;
      rd_lo_q    <= 1'b0;
      rd_byte_q  <= 8'h00;
    end else begin
      ack_sync_q <= {ack_sync_q[0], rd_ack_q};
      rdy_q      <= (ph_q == L_RD) && !LINK_START &&
                    (ack_sync_q[1] == rd_tog_q);
      if (LINK_START) begin
        rd_lo_q <= 1'b0;
      end else if (take_ok) begin
        rd_lo_q <= ~rd_lo_q;
      end
      if ((rd_lo_q ^ take_ok) && !LINK_START) begin
        rd_byte_q <= snap_q[7:0];
      end else begin
        rd_byte_q <= snap_q[15:8];
      end
    end
  end

  assign LINK_RD_BYTE  = rd_byte_q;
  assign LINK_RD_READY = rdy_q;

  // crossing into CLK
  logic [2:0] tog_in;
  logic [2:0] evt;
  assign tog_in = {gc_tog_q, rd_tog_q, wr_tog_q};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic [2:0] s_q;
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          s_q <= 3'b000;
        end else begin
          s_q <= {s_q[1:0], tog_in[gi]};
        end
      end
      assign evt[gi] = s_q[2] ^ s_q[1];
    end
  endgenerate

  logic wr_evt;
  logic rd_evt;
  logic gc_evt;
  assign wr_evt = evt[0];
  assign rd_evt = evt[1];
  assign gc_evt = evt[2];

  // CLK domain state
  conv_state_e st_q;
  logic [2:0]  ld_q;
  word_t       result_q;
  word_t       upper_q;
  word_t       lower_q;
  word_t       scratch_q [4];
  logic        hi_q, lo_q, dr_q, gate_q;
  logic        tn_q, pol_q, src_q;
  logic [1:0]  mode_q, avg_q;
  logic [2:0]  conv_q;
  logic [23:0] pre_q;
  logic [15:0] tick_q;
  logic signed [21:0] acc_q;
  logic [6:0]  nsamp_q;
  logic        nvm_wr_q;
  logic [2:0]  nvm_idx_q;
  word_t       nvm_data_q;
  logic        ev_q;

  function automatic logic [15:0] act_ticks(input logic [1:0] a);
    case (a)
      2'b00:   act_ticks = 16'(`ACT0_US / `TICK_US);
      2'b01:   act_ticks = 16'(`ACT1_US / `TICK_US);
      2'b10:   act_ticks = 16'(`ACT2_US / `TICK_US);
      default: act_ticks = 16'(`ACT3_US / `TICK_US);
    endcase
  endfunction

  function automatic logic [15:0] per_ticks(input logic [2:0] c);
    case (c)
      3'b001:  per_ticks = 16'(`PER1_US / `TICK_US);
      3'b010:  per_ticks = 16'(`PER2_US / `TICK_US);
      3'b011:  per_ticks = 16'(`PER3_US / `TICK_US);
      3'b100:  per_ticks = 16'(`PER4_US / `TICK_US);
      3'b101:  per_ticks = 16'(`PER5_US / `TICK_US);
      3'b110:  per_ticks = 16'(`PER6_US / `TICK_US);
      3'b111:  per_ticks = 16'(`PER7_US / `TICK_US);
      default: per_ticks = 16'h0000;
    endcase
  endfunction

  logic [15:0] act_t, per_t;
  logic [6:0]  samp_max;
  logic        tick_fire, conv_end, stby_end, gt_up, lt_lo, busy;
  word_t       avg_word, ctrl_word, rd_word;
  // a macro literal cannot be part-selected directly
  localparam word_t CTRL_F = `CTRL_FACT;

  assign act_t     = act_ticks(avg_q);
  assign per_t     = per_ticks(conv_q);
  assign tick_fire = (pre_q == 24'(TICK_CYC - 1));
  // at-or-past so a shorter averaging written mid-run still ends it
  assign conv_end  = (st_q == ST_ACTIVE) && tick_fire &&
                     (tick_q >= act_t - 16'h0001);
  assign stby_end  = (st_q == ST_STANDBY) && tick_fire &&
                     (tick_q >= per_t - 16'h0001);
  assign gt_up     = $signed(avg_word) > $signed(upper_q);
  assign lt_lo     = $signed(avg_word) < $signed(lower_q);
  assign busy      = (st_q == ST_LOAD) || NVM_BUSY || nvm_wr_q;

  // block average by slice of the sum
  always_comb begin
    case (avg_q)
      2'b00:   avg_word = acc_q[15:0];
      2'b01:   avg_word = acc_q[18:3];
      2'b10:   avg_word = acc_q[20:5];
      default: avg_word = acc_q[21:6];
    endcase
    case (avg_q)
      2'b00:   samp_max = `AVG_N0;
      2'b01:   samp_max = `AVG_N1;
      2'b10:   samp_max = `AVG_N2;
      default: samp_max = `AVG_N3;
    endcase
  end

  assign ctrl_word = {hi_q, lo_q & ~tn_q, dr_q, busy, mode_q, conv_q,
                      avg_q, tn_q, pol_q, src_q, 2'b00};

  always_comb begin
    case (rd_ptr_q)
      `ADDR_RESULT: rd_word = result_q;
      `ADDR_CTRL:   rd_word = ctrl_word;
      `ADDR_UPPER:  rd_word = upper_q;
      `ADDR_LOWER:  rd_word = lower_q;
      `ADDR_GATE:   rd_word = {gate_q, busy, 14'h0000};
      `ADDR_PART:   rd_word = PART_ID;
      default: begin
        if (rd_ptr_q >= `ADDR_SCR1 && rd_ptr_q <= `ADDR_SCR4) begin
          rd_word = scratch_q[2'(rd_ptr_q - `ADDR_SCR1)];
        end else begin
          rd_word = 16'h0000;
        end
      end
    endcase
  end

  // conversion sequencer
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_q    <= ST_LOAD;
      ld_q    <= 3'h0;
      pre_q   <= 24'h000000;
      tick_q  <= 16'h0000;
      acc_q   <= 22'sh000000;
      nsamp_q <= 7'h00;
    end else if (gc_evt) begin
      st_q <= ST_LOAD;
      ld_q <= 3'h0;
    end else begin
      pre_q <= tick_fire ? 24'h000000 : pre_q + 24'h000001;
      if (tick_fire) begin
        tick_q <= tick_q + 16'h0001;
      end
      case (st_q)
        ST_LOAD: begin
          ld_q <= ld_q + 3'h1;
          if (ld_q == `NVM_WORDS) begin
            st_q <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          pre_q   <= 24'h000000;
          tick_q  <= 16'h0000;
          acc_q   <= 22'sh000000;
          nsamp_q <= 7'h00;
          if (mode_q == `MODE_FREE || mode_q == `MODE_SHOT) begin
            st_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          if (ADC_VALID && nsamp_q < samp_max && !conv_end) begin
            acc_q   <= acc_q + {{6{ADC_SAMPLE[15]}}, ADC_SAMPLE};
            nsamp_q <= nsamp_q + 7'h01;
          end
          if (conv_end) begin
            acc_q   <= 22'sh000000;
            nsamp_q <= 7'h00;
            // standby only if period exceeds active time
            if (mode_q != `MODE_FREE) begin
              st_q <= ST_IDLE;
            end else if (per_t > act_t) begin
              st_q <= ST_STANDBY;
            end else begin
              tick_q <= 16'h0000;
            end
          end
        end
        ST_STANDBY: begin
          if (mode_q == `MODE_DOWN) begin
            st_q <= ST_IDLE;
          end else if (stby_end) begin
            st_q   <= ST_ACTIVE;
            tick_q <= 16'h0000;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  assign CONV_ACTIVE  = (st_q == ST_ACTIVE);
  assign NVM_RD_INDEX = ld_q;

  // result and flags; a set outranks a read clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      result_q <= `RESULT_RST;
      hi_q     <= 1'b0;
      lo_q     <= 1'b0;
      dr_q     <= 1'b0;
    end else if (gc_evt) begin
      result_q <= `RESULT_RST;
      hi_q     <= 1'b0;
      lo_q     <= 1'b0;
      dr_q     <= 1'b0;
    end else begin
      if (conv_end) begin
        result_q <= avg_word;
      end
      if (conv_end && gt_up) begin
        hi_q <= 1'b1;
      end else if (conv_end && tn_q && lt_lo) begin
        hi_q <= 1'b0;
      end else if (rd_evt && rd_ptr_q == `ADDR_CTRL && !tn_q) begin
        hi_q <= 1'b0;
      end
      if (tn_q) begin
        lo_q <= 1'b0;
      end else if (conv_end && lt_lo) begin
        lo_q <= 1'b1;
      end else if (rd_evt && rd_ptr_q == `ADDR_CTRL) begin
        lo_q <= 1'b0;
      end
      if (conv_end) begin
        dr_q <= 1'b1;
      end else if (rd_evt && (rd_ptr_q == `ADDR_CTRL ||
                              rd_ptr_q == `ADDR_RESULT)) begin
        dr_q <= 1'b0;
      end
    end
  end

  // working registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      mode_q  <= CTRL_F[`CW_MODE_HI:`CW_MODE_LO];
      conv_q  <= CTRL_F[`CW_CONV_HI:`CW_CONV_LO];
      avg_q   <= CTRL_F[`CW_AVG_HI:`CW_AVG_LO];
      tn_q    <= CTRL_F[`CW_TN];
      pol_q   <= CTRL_F[`CW_POL];
      src_q   <= CTRL_F[`CW_SRC];
      upper_q <= `UPPER_FACT;
      lower_q <= `LOWER_FACT;
      gate_q  <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        scratch_q[i] <= `SCR_RST;
      end
    end else if (gc_evt) begin
      gate_q <= 1'b0;
    end else if (st_q == ST_LOAD) begin
      // capture stored code for index ld_q-1
      if (ld_q == 3'h1) begin
        // upper run scheme bit not stored
        mode_q <= {1'b0, NVM_RD_DATA[`CW_MODE_LO]};
        conv_q <= NVM_RD_DATA[`CW_CONV_HI:`CW_CONV_LO];
        avg_q  <= NVM_RD_DATA[`CW_AVG_HI:`CW_AVG_LO];
        tn_q   <= NVM_RD_DATA[`CW_TN];
        pol_q  <= NVM_RD_DATA[`CW_POL];
        src_q  <= NVM_RD_DATA[`CW_SRC];
      end else if (ld_q == 3'h2) begin
        upper_q <= NVM_RD_DATA;
      end else if (ld_q == 3'h3) begin
        lower_q <= NVM_RD_DATA;
      end else if (ld_q >= 3'h4) begin
        scratch_q[2'(ld_q - 3'h4)] <= NVM_RD_DATA;
      end
    end else begin
      // single shot falls back to power-down
      if (conv_end && mode_q == `MODE_SHOT) begin
        mode_q <= `MODE_DOWN;
      end
      if (wr_evt) begin
        case (wr_ptr_q)
          `ADDR_CTRL: begin
            // alternate free-run code stored as 00
            if (wr_word_q[`CW_MODE_HI:`CW_MODE_LO] == `MODE_ALT) begin
              mode_q <= `MODE_FREE;
            end else begin
              mode_q <= wr_word_q[`CW_MODE_HI:`CW_MODE_LO];
            end
            conv_q <= wr_word_q[`CW_CONV_HI:`CW_CONV_LO];
            avg_q  <= wr_word_q[`CW_AVG_HI:`CW_AVG_LO];
            tn_q   <= wr_word_q[`CW_TN];
            pol_q  <= wr_word_q[`CW_POL];
            src_q  <= wr_word_q[`CW_SRC];
          end
          `ADDR_UPPER: upper_q <= wr_word_q;
          `ADDR_LOWER: lower_q <= wr_word_q;
          `ADDR_GATE:  gate_q  <= wr_word_q[`GATE_OPEN];
          default: begin
            if (wr_ptr_q >= `ADDR_SCR1 && wr_ptr_q <= `ADDR_SCR4) begin
              scratch_q[2'(wr_ptr_q - `ADDR_SCR1)] <= wr_word_q;
            end
          end
        endcase
      end
    end
  end

  // stored-copy programming
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      nvm_wr_q   <= 1'b0;
      nvm_idx_q  <= 3'h0;
      nvm_data_q <= 16'h0000;
    end else begin
      nvm_wr_q <= 1'b0;
      // open gate programs the stored copy
      if (wr_evt && gate_q && st_q != ST_LOAD && !gc_evt &&
          wr_ptr_q >= `ADDR_CTRL && wr_ptr_q <= `ADDR_SCR4 &&
          wr_ptr_q != `ADDR_GATE) begin
        nvm_wr_q   <= 1'b1;
        nvm_data_q <= wr_word_q;
        if (wr_ptr_q < `ADDR_GATE) begin
          nvm_idx_q <= 3'(wr_ptr_q - `ADDR_CTRL);
        end else begin
          nvm_idx_q <= 3'(wr_ptr_q - 8'h02);
        end
      end
    end
  end

  assign NVM_WR       = nvm_wr_q;
  assign NVM_WR_INDEX = nvm_idx_q;
  assign NVM_WR_DATA  = nvm_data_q;

  // read snapshot and its side effects
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      snap_q   <= 16'h0000;
      rd_ack_q <= 1'b0;
    end else if (rd_evt) begin
      snap_q   <= rd_word;
      rd_ack_q <= ~rd_ack_q;
    end
  end

  logic ev_act, ev_level;
  assign ev_act   = src_q ? dr_q : (hi_q | (lo_q & ~tn_q));
  assign ev_level = pol_q ? ev_act : ~ev_act;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ev_q <= 1'b1;
    end else begin
      ev_q <= ev_level;
    end
  end
  assign EVENT_PIN = ev_q;

  // assertions
  sequence s_conv_end;
    conv_end && !gc_evt;
  endsequence
  sequence s_ctrl_read;
    rd_evt && rd_ptr_q == `ADDR_CTRL && !conv_end && !gc_evt;
  endsequence

  AST_RESULT_LOAD: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q == ST_LOAD) |-> (result_q == `RESULT_RST))
    else $error("result not at power-up value during load");
  AST_DONE_SET: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_conv_end |=> dr_q && result_q == $past(avg_word))
    else $error("done flag or result missing after conversion");
  AST_CTRL_READ: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_ctrl_read |=> !dr_q && !lo_q && (tn_q || !hi_q))
    else $error("control read did not clear flags");
  AST_THERM_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
    tn_q && hi_q && !conv_end && !gc_evt && !wr_evt |=> hi_q)
    else $error("therm flag cleared without result");
  AST_ALERT_SET: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_conv_end ##0 gt_up |=> hi_q)
    else $error("over-upper flag not set");
  AST_MODE_NO_ALT: assert property (@(posedge CLK) disable iff (!RESET_N)
    mode_q != `MODE_ALT)
    else $error("run scheme reads 10");
  AST_SHOT_DONE: assert property (@(posedge CLK) disable iff (!RESET_N)
    s_conv_end ##0 (mode_q == `MODE_SHOT && !wr_evt)
      |=> mode_q == `MODE_DOWN ##1 st_q == ST_IDLE)
    else $error("single shot did not power down");
  AST_LOAD_SPAN: assert property (@(posedge CLK) disable iff (!RESET_N)
    gc_evt ##1 (!gc_evt)[*8] |-> st_q == ST_LOAD ##1 st_q == ST_IDLE)
    else $error("stored code load length wrong");
  AST_LOAD_BUSY: assert property (@(posedge CLK) disable iff (!RESET_N)
    (st_q == ST_LOAD) |-> ctrl_word[`CW_BUSY])
    else $error("busy low during load");
  AST_EVENT_PIN: assert property (@(posedge CLK) disable iff (!RESET_N)
    ##1 EVENT_PIN == $past(ev_level))
    else $error("event pin level wrong");
  AST_BYTE_ORDER: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    take_ok && !rd_lo_q && !LINK_START |=> rd_byte_q == snap_q[7:0])
    else $error("low byte not after high byte");
  AST_PTR_KEEP: assert property (@(posedge LINK_CLK) disable iff (!RESET_N)
    !(LINK_WR_VALID && !LINK_START && ph_q == L_PTR) |=> $stable(ptr_q))
    else $error("pointer changed without pointer byte");

endmodule
